// ==== rtl/spmt_defines.vh ====
// Purpose: shared constants of the spi master transmit block
// Assumes: included by its bare name
// Notes:   offsets are byte addresses on the apb bus
`ifndef SPMT_DEFINES_VH
`define SPMT_DEFINES_VH

// ==========================================
// register offsets
`define SPMT_OFS_MAXCNT   12'h548
`define SPMT_OFS_DONE     12'h54C
`define SPMT_OFS_LIST     12'h550
`define SPMT_OFS_CONFIG   12'h554
`define SPMT_OFS_ORC      12'h5C0
`define SPMT_OFS_TXDATA   12'h600
`define SPMT_OFS_LENGTH   12'h604
`define SPMT_OFS_CTRL     12'h608
`define SPMT_OFS_STATUS   12'h60C

// ==========================================
// field positions and widths
`define SPMT_CNT_W        10
`define SPMT_LIST_W       2
`define SPMT_CFG_ORDER    0
`define SPMT_CFG_CPHA     1
`define SPMT_CFG_CPOL     2
`define SPMT_CTRL_START   0
`define SPMT_ST_BUSY      0
`define SPMT_ST_FULL      1
`define SPMT_ST_EMPTY     2
`define SPMT_ST_RX_LSB    8

// ==========================================
// reset values
`define SPMT_RST_CNT      10'h000
`define SPMT_RST_LIST     2'h0
`define SPMT_RST_CFG      3'h0
`define SPMT_RST_ORC      8'h00

// ==========================================
// timing
`define SPMT_CLK_PERIOD_NS 4
`define SPMT_SCK_PERIOD_NS 128
`define SPMT_HALF_CYCLES  ((`SPMT_SCK_PERIOD_NS + 2*`SPMT_CLK_PERIOD_NS - 1) / (2*`SPMT_CLK_PERIOD_NS))
`define SPMT_FIFO_DEPTH   16
`define SPMT_FIFO_AW      4

`endif

// ==== rtl/spmt_fifo.v ====
// Purpose: small first-in first-out buffer for transmit bytes
// Assumes: depth is a power of two
// Notes:   read data is the head entry, valid while not empty
`timescale 1ns/1ps
`default_nettype none

module spmt_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             full,
  output wire             empty
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // ==========================================
  // flags
  assign full      = (count_reg == DEPTH[AW:0]);
  assign empty     = (count_reg == {(AW+1){1'b0}});
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;
  assign out_data  = mem_reg[rd_ptr_reg];

  // ==========================================
  // storage
  always @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push & ~pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop & ~push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== rtl/spmt_clkdiv.v ====
// Purpose: half-period tick for the serial clock
// Assumes: one system clock
// Notes:   clear restarts the count so the next edge is a full half period away
`timescale 1ns/1ps
`default_nettype none
`include "spmt_defines.vh"

module spmt_clkdiv (
  input  wire clk,
  input  wire rst_n,
  input  wire clear,
  output reg  tick
);

  localparam integer LAST_INT = `SPMT_HALF_CYCLES - 1;
  localparam [4:0]   LAST     = LAST_INT[4:0];
  reg [4:0] cnt_reg;

  // ==========================================
  // counter
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 5'h00;
      tick    <= 1'b0;
    end
    else if (clear)
    begin
      cnt_reg <= 5'h00;
      tick    <= 1'b0;
    end
    else if (cnt_reg == LAST)
    begin
      cnt_reg <= 5'h00;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 5'h01;
      tick    <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/spmt_top.v ====
// Purpose: spi master transmit path with apb registers
// Assumes: apb master per protocol, slave samples per chosen mode
// Notes:   one byte is 16 serial clock edges, cs held low for the whole transfer
// What this block does
// - order bit zero msb first, one lsb
// - phase zero: sample leading, shift trailing
// - phase one: sample trailing, shift leading
// - polarity sets idle and active clock level
// - past maximum count bytes send fill character
// - never take more than maximum count bytes
// - readable count of bytes taken last transfer
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "spmt_defines.vh"

module spmt_top (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output reg         PSLVERR,
  output reg         SPI_SCK,
  output reg         SPI_MOSI,
  output reg         SPI_CS_N,
  input  wire        SPI_MISO
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_LOAD  = 2'h1;
  localparam [1:0] ST_SHIFT = 2'h2;
  localparam [1:0] ST_END   = 2'h3;

  reg                    rst_s1_reg;
  reg                    rst_s2_reg;
  wire                   rst_n;
  reg                    miso_s1_reg;
  reg                    miso_s2_reg;

  reg [`SPMT_CNT_W-1:0]  max_cnt_reg;
  reg [`SPMT_CNT_W-1:0]  done_cnt_reg;
  reg [`SPMT_LIST_W-1:0] list_reg;
  reg [2:0]              cfg_reg;
  reg [7:0]              orc_reg;
  reg [`SPMT_CNT_W-1:0]  len_reg;
  reg [7:0]              rx_last_reg;

  reg [1:0]              state_reg;
  reg [`SPMT_CNT_W-1:0]  taken_reg;
  reg [`SPMT_CNT_W-1:0]  sent_reg;
  reg [3:0]              edge_reg;
  reg [7:0]              tx_sh_reg;
  reg [7:0]              rx_sh_reg;
  reg                    active_reg;
  reg                    mosi_reg;

  wire                   setup;
  wire                   access;
  wire                   wr_data;
  wire                   wr_en;
  wire                   mapped;
  wire                   start;
  wire                   busy;
  wire                   tick;
  wire                   div_clear;
  wire                   fifo_in_ready;
  wire                   fifo_valid;
  wire                   fifo_pop;
  wire [7:0]             fifo_byte;
  wire                   fifo_full;
  wire                   fifo_empty;
  wire                   need_fifo;
  wire                   can_load;
  wire [7:0]             src_byte;
  wire [7:0]             src_rev;
  wire [7:0]             tx_ord;
  wire [7:0]             rx_rev;
  wire                   order;
  wire                   cpha;
  wire                   cpol;
  wire                   leading;
  wire                   last_edge;

  // ==========================================
  // reset release and pin synchronisers
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  assign rst_n = rst_s2_reg;

  // miso is asynchronous to us; only the second stage is read
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end
    else
    begin
      miso_s1_reg <= SPI_MISO;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // ==========================================
  // apb decode
  assign setup   = PSEL & ~PENABLE;
  assign access  = PSEL & PENABLE;
  assign wr_data = PWRITE & (PADDR == `SPMT_OFS_TXDATA);
  // a full buffer stalls the write until the serial side drains it
  assign PREADY  = ~(wr_data & ~fifo_in_ready);
  assign wr_en   = access & PWRITE & PREADY;
  assign start   = wr_en & (PADDR == `SPMT_OFS_CTRL) & PWDATA[`SPMT_CTRL_START];
  assign busy    = (state_reg != ST_IDLE);

  assign mapped  = (PADDR == `SPMT_OFS_MAXCNT) | (PADDR == `SPMT_OFS_DONE) |
                   (PADDR == `SPMT_OFS_LIST)   | (PADDR == `SPMT_OFS_CONFIG) |
                   (PADDR == `SPMT_OFS_ORC)    | (PADDR == `SPMT_OFS_TXDATA) |
                   (PADDR == `SPMT_OFS_LENGTH) | (PADDR == `SPMT_OFS_CTRL) |
                   (PADDR == `SPMT_OFS_STATUS);

  assign order = cfg_reg[`SPMT_CFG_ORDER];
  assign cpha  = cfg_reg[`SPMT_CFG_CPHA];
  assign cpol  = cfg_reg[`SPMT_CFG_CPOL];

  // ==========================================
  // read data, captured in the setup cycle
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
    else if (setup)
    begin
      PSLVERR <= ~mapped;
      PRDATA  <= 32'h00000000;
      case (PADDR)
        `SPMT_OFS_MAXCNT: PRDATA[`SPMT_CNT_W-1:0]  <= max_cnt_reg;
        `SPMT_OFS_DONE:   PRDATA[`SPMT_CNT_W-1:0]  <= done_cnt_reg;
        `SPMT_OFS_LIST:   PRDATA[`SPMT_LIST_W-1:0] <= list_reg;
        `SPMT_OFS_CONFIG: PRDATA[2:0]              <= cfg_reg;
        `SPMT_OFS_ORC:    PRDATA[7:0]              <= orc_reg;
        `SPMT_OFS_LENGTH: PRDATA[`SPMT_CNT_W-1:0]  <= len_reg;
        `SPMT_OFS_STATUS:
        begin
          PRDATA[`SPMT_ST_BUSY]  <= busy;
          PRDATA[`SPMT_ST_FULL]  <= fifo_full;
          PRDATA[`SPMT_ST_EMPTY] <= fifo_empty;
          PRDATA[`SPMT_ST_RX_LSB+7:`SPMT_ST_RX_LSB] <= rx_last_reg;
        end
        default:          PRDATA <= 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // writable registers
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      max_cnt_reg <= `SPMT_RST_CNT;
      list_reg    <= `SPMT_RST_LIST;
      cfg_reg     <= `SPMT_RST_CFG;
      orc_reg     <= `SPMT_RST_ORC;
      len_reg     <= `SPMT_RST_CNT;
    end
    else if (wr_en)
    begin
      case (PADDR)
        `SPMT_OFS_MAXCNT: max_cnt_reg <= PWDATA[`SPMT_CNT_W-1:0];
        `SPMT_OFS_LIST:   list_reg    <= PWDATA[`SPMT_LIST_W-1:0];
        `SPMT_OFS_CONFIG: cfg_reg     <= PWDATA[2:0];
        `SPMT_OFS_ORC:    orc_reg     <= PWDATA[7:0];
        `SPMT_OFS_LENGTH: len_reg     <= PWDATA[`SPMT_CNT_W-1:0];
        default:          len_reg     <= len_reg;
      endcase
    end
  end

  // ==========================================
  // transmit buffer and divider
  spmt_fifo #(
    .WIDTH (8),
    .DEPTH (`SPMT_FIFO_DEPTH),
    .AW    (`SPMT_FIFO_AW)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (rst_n),
    .in_valid  (access & wr_data),
    .in_ready  (fifo_in_ready),
    .in_data   (PWDATA[7:0]),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_byte),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  spmt_clkdiv u_div (
    .clk   (CLK),
    .rst_n (rst_n),
    .clear (div_clear),
    .tick  (tick)
  );

  // ==========================================
  // byte source and bit order
  assign need_fifo = (taken_reg < max_cnt_reg);
  assign can_load  = ~need_fifo | fifo_valid;
  assign fifo_pop  = (state_reg == ST_LOAD) & need_fifo & fifo_valid;
  assign src_byte  = need_fifo ? fifo_byte : orc_reg;
  assign div_clear = (state_reg == ST_LOAD) | (state_reg == ST_IDLE);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_rev
      assign src_rev[gi] = src_byte[7-gi];
      assign rx_rev[gi]  = rx_sh_reg[7-gi];
    end
  endgenerate

  // bit sent first always sits in bit 7 of tx_ord; with phase zero it goes straight to mosi at load
  assign tx_ord    = order ? src_rev : src_byte;
  assign leading   = ~edge_reg[0];
  assign last_edge = (edge_reg == 4'hF);

  // ==========================================
  // serial engine
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= ST_IDLE;
      taken_reg    <= `SPMT_RST_CNT;
      sent_reg     <= `SPMT_RST_CNT;
      done_cnt_reg <= `SPMT_RST_CNT;
      edge_reg     <= 4'h0;
      tx_sh_reg    <= 8'h00;
      rx_sh_reg    <= 8'h00;
      rx_last_reg  <= 8'h00;
      active_reg   <= 1'b0;
      mosi_reg     <= 1'b0;
      SPI_CS_N     <= 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          SPI_CS_N   <= 1'b1;
          active_reg <= 1'b0;
          if (start)
          begin
            taken_reg <= `SPMT_RST_CNT;
            sent_reg  <= `SPMT_RST_CNT;
            SPI_CS_N  <= 1'b0;
            state_reg <= (len_reg == `SPMT_RST_CNT) ? ST_END : ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          // waiting here on an empty buffer keeps the bus clock stopped
          if (can_load)
          begin
            if (need_fifo)
            begin
              taken_reg <= taken_reg + 1'b1;
            end
            edge_reg  <= 4'h0;
            state_reg <= ST_SHIFT;
            if (cpha)
            begin
              tx_sh_reg <= tx_ord;
            end
            else
            begin
              mosi_reg  <= tx_ord[7];
              tx_sh_reg <= {tx_ord[6:0], 1'b0};
            end
          end
        end
        ST_SHIFT:
        begin
          if (tick)
          begin
            active_reg <= ~active_reg;
            edge_reg   <= edge_reg + 4'h1;
            if (leading ^ cpha)
            begin
              rx_sh_reg <= {rx_sh_reg[6:0], miso_s2_reg};
            end
            if (cpha & leading)
            begin
              mosi_reg  <= tx_sh_reg[7];
              tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
            if (~cpha & ~leading & ~last_edge)
            begin
              mosi_reg  <= tx_sh_reg[7];
              tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
            if (last_edge)
            begin
              sent_reg  <= sent_reg + 1'b1;
              state_reg <= (sent_reg + 1'b1 == len_reg) ? ST_END : ST_LOAD;
            end
          end
          if (last_edge & ~tick)
          begin
            rx_last_reg <= order ? rx_rev : rx_sh_reg;
          end
        end
        ST_END:
        begin
          // one half period of hold before chip select rises
          if (tick)
          begin
            SPI_CS_N     <= 1'b1;
            done_cnt_reg <= taken_reg;
            state_reg    <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // clock and data pins share one stage so data moves with its clock edge
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SPI_SCK  <= 1'b0;
      SPI_MOSI <= 1'b0;
    end
    else
    begin
      SPI_SCK  <= cpol ^ active_reg;
      SPI_MOSI <= mosi_reg;
    end
  end

endmodule

`default_nettype wire

// ==== tb/spmt_top_sva.sv ====
// Purpose: port checks of the spi master transmit block
// Assumes: config and length tracked from apb writes
// Notes:   config is never changed inside a frame
`timescale 1ns/1ps
`default_nettype none
`include "spmt_defines.vh"

module spmt_top_sva (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        SPI_SCK,
  input wire logic        SPI_MOSI,
  input wire logic        SPI_CS_N
);
  logic [2:0]  cfg_reg;
  logic [9:0]  len_reg;
  logic [13:0] edge_reg;
  logic        sck_q;
  wire         wr = PSEL && PENABLE && PWRITE && PREADY;

  // ==========
  // shadow of config and length
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cfg_reg  <= 3'h0;
      len_reg  <= 10'h000;
      edge_reg <= 14'h0000;
      sck_q    <= 1'b0;
    end
    else
    begin
      if (wr && PADDR == `SPMT_OFS_CONFIG)
        cfg_reg <= PWDATA[2:0];
      if (wr && PADDR == `SPMT_OFS_LENGTH)
        len_reg <= PWDATA[9:0];
      edge_reg <= SPI_CS_N ? 14'h0000 : edge_reg + {13'h0000, SPI_SCK != sck_q};
      sck_q    <= SPI_SCK;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ==========
  // serial framing
  a_frame_len: assert property ($rose(SPI_CS_N) |-> edge_reg == {len_reg, 4'h0})
    else $error("edge count does not match frame length");
  a_cs_tail: assert property ($rose(SPI_CS_N) |-> $past(SPI_SCK) == cfg_reg[2])
    else $error("clock not idle when select rises");
  a_start_idle: assert property ($fell(SPI_CS_N) |-> ##2 (SPI_SCK == cfg_reg[2]) [*8])
    else $error("clock not idle at frame start");
  a_half_period: assert property (!SPI_CS_N && $changed(SPI_SCK) |=> $stable(SPI_SCK) [*8])
    else $error("clock half period too short");
  a_shift_cpha0: assert property (!SPI_CS_N && !cfg_reg[1] && $changed(SPI_SCK) && $changed(SPI_MOSI)
    |-> SPI_SCK == cfg_reg[2]) else $error("data moved on leading edge");
  a_hold_cpha0: assert property (!SPI_CS_N && !cfg_reg[1] && $changed(SPI_SCK) && SPI_SCK != cfg_reg[2]
    |-> $stable(SPI_MOSI)) else $error("data unstable at sampling edge");
  a_shift_cpha1: assert property (!SPI_CS_N && cfg_reg[1] && $changed(SPI_SCK) && $changed(SPI_MOSI)
    |-> SPI_SCK != cfg_reg[2]) else $error("data moved on trailing edge");
  a_hold_cpha1: assert property (!SPI_CS_N && cfg_reg[1] && $changed(SPI_SCK) && SPI_SCK == cfg_reg[2]
    |-> $stable(SPI_MOSI)) else $error("data unstable at sampling edge");
endmodule
`default_nettype wire

// ==== tb/spmt_slave_model.sv ====
// Purpose: behavioural spi slave recording bytes seen on mosi
// Assumes: mode given as cpol, cpha by the bench
// Notes:   no clock of its own, reacts to sck edges inside a frame
`timescale 1ns/1ps
`default_nettype none

module spmt_slave_model (
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [1:0] mode,
  output var  logic       miso
);
  logic [7:0] sh_reg = 8'h00;
  logic       sck_q  = 1'b0;
  int         nbits  = 0;
  logic [7:0] rx_q [$];

  initial miso = 1'b0;

  // ==========
  // serial side
  always @(sck or cs_n)
  begin
    if (cs_n)
    begin
      miso  = ~miso; // released: inverse so a stale bit never reads as data
      nbits = 0;
    end
    else if (sck !== sck_q)
    begin
      if ((sck != mode[1]) ^ mode[0])
      begin
        sh_reg = {sh_reg[6:0], mosi};
        nbits++;
        if (nbits % 8 == 0)
          rx_q.push_back(sh_reg);
      end
      else
        miso = ~miso;
    end
    sck_q = sck;
  end
endmodule
`default_nettype wire

// ==== tb/test_spmt_top.sv ====
// Purpose: self-checking bench for the spi master transmit block
// Assumes: apb master here, slave model on the serial side
// Notes:   longest frame fills the fifo before start, last byte follows it
`timescale 1ns/1ps
`default_nettype none
`include "spmt_defines.vh"

module test_spmt_top;
  logic        CLK     = 1'b0;
  logic        RST_N   = 1'b0;
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [11:0] PADDR   = 12'h000;
  logic [31:0] PWDATA  = 32'h00000000;
  wire  [31:0] PRDATA;
  wire         PREADY;
  wire         PSLVERR;
  wire         SPI_SCK;
  wire         SPI_MOSI;
  wire         SPI_CS_N;
  wire         SPI_MISO;
  logic [1:0]  mode    = 2'h0;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          n_tests   = 0;

  always #2 CLK = ~CLK;

  spmt_top u_dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SPI_SCK(SPI_SCK), .SPI_MOSI(SPI_MOSI), .SPI_CS_N(SPI_CS_N), .SPI_MISO(SPI_MISO));
  spmt_slave_model u_slave (.cs_n(SPI_CS_N), .sck(SPI_SCK), .mosi(SPI_MOSI), .mode(mode), .miso(SPI_MISO));

  // ==========
  // shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
      @(posedge CLK);
    rd      = PRDATA;
    err     = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  function automatic logic [7:0] dat(input int k);
    return 8'h31 + k[7:0] * 8'h27;
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic t_regs;
    logic [11:0] ofs [5];
    logic [31:0] msk [5];
    ofs = '{`SPMT_OFS_MAXCNT, `SPMT_OFS_DONE, `SPMT_OFS_LIST, `SPMT_OFS_CONFIG, `SPMT_OFS_ORC};
    msk = '{32'h3FF, 32'h0, 32'h3, 32'h7, 32'hFF};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset value", 32'h0, rd);
      apb(1'b1, ofs[i], 32'hFFFFFFFF);
      apb(1'b0, ofs[i], 32'h0);
      chk("read back", msk[i], rd);
    end
    apb(1'b0, 12'h400, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("end of register test");
  endtask

  task automatic t_frame(input logic [2:0] cfg, input int mx, input int ln, input int np);
    logic [7:0] d;
    logic [7:0] e;
    u_slave.rx_q.delete();
    mode <= cfg[2:1];
    apb(1'b1, `SPMT_OFS_CONFIG, {29'h0, cfg});
    apb(1'b1, `SPMT_OFS_MAXCNT, 32'(mx));
    apb(1'b1, `SPMT_OFS_LENGTH, 32'(ln));
    apb(1'b1, `SPMT_OFS_ORC, {24'h0, 8'h5A ^ {5'h00, cfg}});
    for (int k = 0; k < np && k < 16; k++)
      apb(1'b1, `SPMT_OFS_TXDATA, {24'h0, dat(k)});
    if (np >= 16)
    begin
      apb(1'b0, `SPMT_OFS_STATUS, 32'h0);
      chk("fifo full", 32'h1, {31'h0, rd[1]});
    end
    apb(1'b1, `SPMT_OFS_CTRL, 32'h1);
    for (int k = 16; k < np; k++)
      apb(1'b1, `SPMT_OFS_TXDATA, {24'h0, dat(k)});
    for (int k = 0; k < 20000 && SPI_CS_N !== 1'b1; k++)
      @(posedge CLK);
    chk("frame end", 32'h1, {31'h0, SPI_CS_N});
    apb(1'b0, `SPMT_OFS_DONE, 32'h0);
    chk("bytes done", 32'(np), rd);
    apb(1'b0, `SPMT_OFS_STATUS, 32'h0);
    chk("fifo empty", 32'h1, {31'h0, rd[2]});
    chk("frame bytes", 32'(ln), 32'(u_slave.rx_q.size()));
    for (int i = 0; i < ln; i++)
    begin
      d = (i < np) ? dat(i) : 8'h5A ^ {5'h00, cfg};
      for (int j = 0; j < 8; j++)
        e[j] = cfg[0] ? d[7 - j] : d[j];
      chk("mosi byte", {24'h0, e}, {24'h0, u_slave.rx_q[i]});
    end
    $display("end of frame test, config %h", cfg);
  endtask

  // ==========
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    t_regs();
    t_frame(3'h0, 2, 3, 2);
    t_frame(3'h3, 5, 3, 3);
    t_frame(3'h5, 0, 2, 0);
    t_frame(3'h6, 1, 1, 1);
    t_frame(3'h1, 17, 17, 17);
    t_frame(3'h0, 4, 0, 0);
    tally_and_finish();
  end

  initial
  begin
    repeat (60000) @(posedge CLK);
    bad_count++;
    $display("BAD watchdog expected end seen hang");
    tally_and_finish();
  end
endmodule

bind spmt_top spmt_top_sva u_sva (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .SPI_SCK(SPI_SCK), .SPI_MOSI(SPI_MOSI), .SPI_CS_N(SPI_CS_N));
`default_nettype wire
